//--- shared/instr_unit_pkg.sv
// Constants and carriers for the instruction-unit control registers.
// Assumes a single core clock; privileged moves arrive as one-cycle strobes.
package instr_unit_pkg;
	localparam int XLEN = 64;
	localparam int IDX_W = 8;
	localparam int TB_ENTRIES = 16;
	localparam int GH_W = 2;
	localparam int SPACE_W = 8;

	// Privileged register indices
	localparam logic [IDX_W-1:0] IDX_ITB_INV = 8'h03;
	localparam logic [IDX_W-1:0] IDX_PROF_PC = 8'h04;
	localparam logic [IDX_W-1:0] IDX_EXC_PC = 8'h06;
	localparam logic [IDX_W-1:0] IDX_PTE_FMT = 8'h07;
	localparam logic [5:0] IDX_IEM_SEL = 6'h02;
	localparam int IDX_SEL_HI = 7;
	localparam int IDX_SEL_LO = 2;
	localparam int IDX_WE_IEN = 1;
	localparam int IDX_WE_MODE = 0;

	// Page number field of the invalidate value
	localparam int VPN_HI = 47;
	localparam int VPN_LO = 13;
	localparam int VPN_W = VPN_HI - VPN_LO + 1;
	localparam int GH_BITS_PER_STEP = 3;

	// Context register space number field
	localparam int CTX_SPACE_HI = 46;
	localparam int CTX_SPACE_LO = 39;

	// Enable and mode layout
	localparam int IEN_HI = 38;
	localparam int IEN_LO = 13;
	localparam int IEN_W = IEN_HI - IEN_LO + 1;
	localparam int EXT_HI = 38;
	localparam int EXT_LO = 33;
	localparam int SERIAL_BIT = 32;
	localparam int CORR_BIT = 31;
	localparam int PERF_HI = 30;
	localparam int PERF_LO = 29;
	localparam int SOFT_HI = 28;
	localparam int SOFT_LO = 14;
	localparam int ASYNC_BIT = 13;
	localparam int MODE_HI = 4;
	localparam int MODE_LO = 3;
	localparam int SOFT_W = SOFT_HI - SOFT_LO + 1;
	localparam logic [IEN_W-1:0] IEN_RESET = 26'h0000000;

	typedef enum logic [1:0] {
		MODE_KERNEL     = 2'h0,
		MODE_EXECUTIVE  = 2'h1,
		MODE_SUPERVISOR = 2'h2,
		MODE_USER       = 2'h3
	} privilege_level_t;

	// Profile and exception PC layout
	localparam int PC_ZERO_BIT = 1;
	localparam int PC_PRIV_BIT = 0;

	// Control register fields feeding the PTE formatter
	localparam int PTB_W = 34;
	localparam int PTB_LO = 30;
	localparam int PTE_SHIFT = 3;
	localparam int VA43_MSB = 42;
	localparam int VA48_MSB = 47;
	localparam int VA32_MSB = 31;
	localparam int PTB32_LO = 22;

	typedef struct packed {
		logic             valid;
		logic [VPN_W-1:0] vpn;
		logic [SPACE_W-1:0] space_id;
		logic             all_space_match_bit;
		logic [GH_W-1:0]  gran_hint;
	} tb_tag_t;

	typedef struct packed {
		logic             wr;
		logic             rd;
		logic [IDX_W-1:0] idx;
		logic [XLEN-1:0]  wdata;
	} priv_req_t;

	typedef struct packed {
		logic            fault;
		logic            interrupt;
		logic [XLEN-1:0] fault_pc;
		logic [XLEN-1:0] next_pc;
		logic            privcode_mode;
	} exc_event_t;
endpackage

//--- verilog/instr_unit_control_regs.sv
// Instruction-unit privileged registers: single-entry translation invalidate,
// profiled PC, exception PC, PTE format and interrupt enable/mode.
// Assumes privileged moves and exception events are single-cycle pulses on clk_i.
//
// Functional notes
// RQ1: Invalidate write kills entries matching page bits and context space number, hint-reduced.
// RQ2: Invalidate write also kills matching entries marked all-space regardless of space number.
// RQ3: Invalidate write never touches the instruction cache.
// RQ4: Profiled PC is read-only; upper bits hold last profiled instruction address.
// RQ5: Profiled PC bit one reads zero; bit zero flags physical privcode address.
// RQ6: Exception PC updates on every exception or interrupt; bit zero marks privcode mode.
// RQ7: Faults and synchronous traps capture the faulting instruction PC.
// RQ8: Interrupts capture the PC that would have executed next.
// RQ9: PTE format register forms address from exception PC and control fields.
// RQ10: Each wide/short format combination uses its own layout; the code gives both short combinations (01, 11) one shared layout.
// RQ11: Enable/mode register selected when index bits seven to two equal 000010.
// RQ12: Index bits one and zero enable writes of enable and mode fields.
// RQ13: A read returns both fields together.
// RQ14: Holds external, serial line and corrected read error enables.
// RQ15: Holds performance counter and software level enables.
// RQ16: Async trap enable gates requests also enabled by per-mode mask.
// RQ17: Mode in bits four to three; listed reserved bits read zero.
// RQ18: Software interrupt raised only when request and enable both set.
`timescale 1ns/1ns
module instr_unit_control_regs (
	input  wire logic                                           clk_i,
	input  wire logic                                           rst_i,
	input  wire instr_unit_pkg::priv_req_t                      req_i,
	output logic [instr_unit_pkg::XLEN-1:0]                     rdata_o,
	input  wire logic                                           tb_fill_i,
	input  wire instr_unit_pkg::tb_tag_t                        tb_fill_tag_i,
	input  wire logic [$clog2(instr_unit_pkg::TB_ENTRIES)-1:0]  tb_fill_slot_i,
	output logic [instr_unit_pkg::TB_ENTRIES-1:0]               tb_valid_o,
	output logic                                                icache_flush_o,
	input  wire logic [instr_unit_pkg::SPACE_W-1:0]             ctx_space_id_i,
	input  wire logic                                           profile_i,
	input  wire logic [instr_unit_pkg::XLEN-1:0]                profile_pc_i,
	input  wire logic                                           profile_phys_i,
	input  wire instr_unit_pkg::exc_event_t                     exc_i,
	input  wire logic [instr_unit_pkg::PTB_W-1:0]               page_table_base_i,
	input  wire logic                                           wide_va_select_i,
	input  wire logic                                           short_pte_format_i,
	input  wire logic [instr_unit_pkg::SOFT_W-1:0]              soft_int_request_i,
	input  wire logic [3:0]                                     async_trap_mask_i,
	input  wire logic [3:0]                                     async_trap_request_i,
	output logic [instr_unit_pkg::SOFT_W-1:0]                   soft_irq_o,
	output logic [3:0]                                          async_trap_o,
	output logic [1:0]                                          privilege_level_o
);
	localparam int TBN    = instr_unit_pkg::TB_ENTRIES;
	localparam int SLOT_W = $clog2(TBN);
	localparam int XL = instr_unit_pkg::XLEN;

	////////////////////////////////////////////////////////////////////////////
	// Request decode
	logic iem_sel;
	logic inv_wr;
	assign iem_sel = req_i.idx[instr_unit_pkg::IDX_SEL_HI:instr_unit_pkg::IDX_SEL_LO]
		== instr_unit_pkg::IDX_IEM_SEL; // see RQ11
	assign inv_wr = req_i.wr && (req_i.idx == instr_unit_pkg::IDX_ITB_INV);

	////////////////////////////////////////////////////////////////////////////
	// Translation buffer tags
	instr_unit_pkg::tb_tag_t tags_q [TBN];
	instr_unit_pkg::tb_tag_t tags_d [TBN];
	logic [instr_unit_pkg::VPN_W-1:0] inv_vpn;
	assign inv_vpn = req_i.wdata[instr_unit_pkg::VPN_HI:instr_unit_pkg::VPN_LO];

	genvar g;
	generate
		for (g = 0; g < TBN; g++) begin : g_tb
			logic [instr_unit_pkg::VPN_W-1:0] mask;
			logic                             vpn_hit;
			logic                             kill;
			// Each hint step widens the page by three address bits
			assign mask = {instr_unit_pkg::VPN_W{1'b1}}
				<< (int'(tags_q[g].gran_hint) * instr_unit_pkg::GH_BITS_PER_STEP);
			assign vpn_hit = ((tags_q[g].vpn ^ inv_vpn) & mask) == '0; // see RQ1
			assign kill = inv_wr && tags_q[g].valid && vpn_hit
				&& (tags_q[g].all_space_match_bit // see RQ2
				|| tags_q[g].space_id == ctx_space_id_i); // see RQ1
			always_comb begin
				tags_d[g] = tags_q[g];
				if (tb_fill_i && tb_fill_slot_i == SLOT_W'(g)) begin
					tags_d[g] = tb_fill_tag_i;
				end else if (kill) begin
					tags_d[g].valid = 1'b0;
				end
			end
			always_ff @(posedge clk_i or posedge rst_i) begin
				if (rst_i) begin
					tags_q[g] <= '0;
				end else begin
					tags_q[g] <= tags_d[g];
				end
			end
			assign tb_valid_o[g] = tags_q[g].valid;
		end
	endgenerate

	// Fetch lookups use virtual tags, so dropping a mapping leaves cached lines alone
	assign icache_flush_o = 1'b0; // see RQ3

	////////////////////////////////////////////////////////////////////////////
	// Profiled PC and exception PC
	logic [XL-1:0] prof_pc_q, prof_pc_d;
	logic [XL-1:0] exc_pc_q, exc_pc_d;
	always_comb begin
		prof_pc_d = prof_pc_q;
		if (profile_i) begin
			prof_pc_d = profile_pc_i; // see RQ4
			prof_pc_d[instr_unit_pkg::PC_ZERO_BIT] = 1'b0; // see RQ5
			prof_pc_d[instr_unit_pkg::PC_PRIV_BIT] = profile_phys_i; // see RQ5
		end
		exc_pc_d = exc_pc_q;
		// A fault outranks a simultaneous interrupt; it is the older event
		if (exc_i.fault) begin
			exc_pc_d = exc_i.fault_pc; // see RQ7
		end else if (exc_i.interrupt) begin
			exc_pc_d = exc_i.next_pc; // see RQ8
		end
		if (exc_i.fault || exc_i.interrupt) begin
			exc_pc_d[instr_unit_pkg::PC_PRIV_BIT] = exc_i.privcode_mode; // see RQ6
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prof_pc_q <= '0;
			exc_pc_q  <= '0;
		end else begin
			prof_pc_q <= prof_pc_d;
			exc_pc_q  <= exc_pc_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// PTE format (combinational view of exception PC and control fields)
	logic [XL-1:0] pte_fmt;
	always_comb begin
		pte_fmt = '0;
		unique case ({wide_va_select_i, short_pte_format_i}) // see RQ10
			2'b10: begin
				pte_fmt[XL-1:instr_unit_pkg::PTB_LO] = page_table_base_i; // see RQ9
				pte_fmt[instr_unit_pkg::VA48_MSB-instr_unit_pkg::VPN_LO+instr_unit_pkg::PTE_SHIFT:
					instr_unit_pkg::PTE_SHIFT] =
					exc_pc_q[instr_unit_pkg::VA48_MSB:instr_unit_pkg::VPN_LO];
			end
			2'b01, 2'b11: begin
				// Base stays aligned to the top; the bits below it down to the short floor read zero
				pte_fmt[XL-1:instr_unit_pkg::PTB32_LO] =
					{page_table_base_i, {(instr_unit_pkg::PTB_LO-instr_unit_pkg::PTB32_LO){1'b0}}}; // see RQ9
				pte_fmt[instr_unit_pkg::VA32_MSB-instr_unit_pkg::VPN_LO+instr_unit_pkg::PTE_SHIFT:
					instr_unit_pkg::PTE_SHIFT] =
					exc_pc_q[instr_unit_pkg::VA32_MSB:instr_unit_pkg::VPN_LO];
			end
			2'b00: begin
				pte_fmt[XL-1:instr_unit_pkg::PTB_LO] = page_table_base_i; // see RQ9
				pte_fmt[instr_unit_pkg::VA43_MSB-instr_unit_pkg::VPN_LO+instr_unit_pkg::PTE_SHIFT:
					instr_unit_pkg::PTE_SHIFT] =
					exc_pc_q[instr_unit_pkg::VA43_MSB:instr_unit_pkg::VPN_LO];
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt enable and mode
	logic [instr_unit_pkg::IEN_W-1:0] ien_q, ien_d;
	logic [1:0]                       mode_q, mode_d;
	always_comb begin
		ien_d  = ien_q;
		mode_d = mode_q;
		if (req_i.wr && iem_sel && req_i.idx[instr_unit_pkg::IDX_WE_IEN]) begin
			ien_d = req_i.wdata[instr_unit_pkg::IEN_HI:instr_unit_pkg::IEN_LO]; // see RQ12, RQ14, RQ15
		end
		if (req_i.wr && iem_sel && req_i.idx[instr_unit_pkg::IDX_WE_MODE]) begin
			mode_d = req_i.wdata[instr_unit_pkg::MODE_HI:instr_unit_pkg::MODE_LO]; // see RQ12, RQ17
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ien_q  <= instr_unit_pkg::IEN_RESET;
			mode_q <= instr_unit_pkg::MODE_KERNEL;
		end else begin
			ien_q  <= ien_d;
			mode_q <= mode_d;
		end
	end
	assign privilege_level_o = mode_q;

	logic [XL-1:0] iem_view;
	always_comb begin
		iem_view = '0; // see RQ17
		iem_view[instr_unit_pkg::IEN_HI:instr_unit_pkg::IEN_LO] = ien_q; // see RQ13
		iem_view[instr_unit_pkg::MODE_HI:instr_unit_pkg::MODE_LO] = mode_q; // see RQ13
	end

	assign soft_irq_o = soft_int_request_i
		& ien_q[instr_unit_pkg::SOFT_HI-instr_unit_pkg::IEN_LO:instr_unit_pkg::SOFT_LO-instr_unit_pkg::IEN_LO]; // see RQ18
	assign async_trap_o = async_trap_request_i & async_trap_mask_i
		& {4{ien_q[instr_unit_pkg::ASYNC_BIT-instr_unit_pkg::IEN_LO]}}; // see RQ16

	////////////////////////////////////////////////////////////////////////////
	// Read data, registered one cycle after the read strobe
	logic [XL-1:0] rdata_q, rdata_d;
	always_comb begin
		rdata_d = rdata_q;
		if (req_i.rd) begin
			rdata_d = '0;
			if (iem_sel) begin
				rdata_d = iem_view;
			end else if (req_i.idx == instr_unit_pkg::IDX_PROF_PC) begin
				rdata_d = prof_pc_q;
			end else if (req_i.idx == instr_unit_pkg::IDX_EXC_PC) begin
				rdata_d = exc_pc_q;
			end else if (req_i.idx == instr_unit_pkg::IDX_PTE_FMT) begin
				rdata_d = pte_fmt;
			end
		end
	end
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end
	assign rdata_o = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	property p_iem_write_mode;
		@(posedge clk_i) disable iff (rst_i)
		(req_i.wr && iem_sel && req_i.idx[0]) |=> mode_q == $past(req_i.wdata[4:3]);
	endproperty
	a_iem_write_mode: assert property (p_iem_write_mode) else $error("mode not written"); // see RQ12

	property p_iem_mode_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(req_i.wr && iem_sel && req_i.idx[0]) |=> $stable(mode_q);
	endproperty
	a_iem_mode_hold: assert property (p_iem_mode_hold) else $error("mode changed unselected"); // see RQ12

	property p_ien_hold;
		@(posedge clk_i) disable iff (rst_i)
		!(req_i.wr && iem_sel && req_i.idx[1]) |=> $stable(ien_q);
	endproperty
	a_ien_hold: assert property (p_ien_hold) else $error("enables changed unselected"); // see RQ14

	property p_iem_read;
		@(posedge clk_i) disable iff (rst_i)
		(req_i.rd && iem_sel) |=> rdata_o[4:3] == $past(mode_q) && rdata_o[2:0] == 3'h0
			&& rdata_o[12:5] == 8'h00 && rdata_o[63:39] == 25'h0;
	endproperty
	a_iem_read: assert property (p_iem_read) else $error("mode read wrong"); // see RQ13

	property p_prof_zero;
		@(posedge clk_i) disable iff (rst_i)
		profile_i |=> prof_pc_q[1] == 1'b0 && prof_pc_q[63:2] == $past(profile_pc_i[63:2]);
	endproperty
	a_prof_zero: assert property (p_prof_zero) else $error("profiled pc wrong"); // see RQ5

	property p_exc_fault;
		@(posedge clk_i) disable iff (rst_i)
		exc_i.fault |=> exc_pc_q[63:1] == $past(exc_i.fault_pc[63:1]) && exc_pc_q[0] == $past(exc_i.privcode_mode);
	endproperty
	a_exc_fault: assert property (p_exc_fault) else $error("fault pc wrong"); // see RQ7

	property p_exc_irq;
		@(posedge clk_i) disable iff (rst_i)
		(exc_i.interrupt && !exc_i.fault) |=> exc_pc_q[63:1] == $past(exc_i.next_pc[63:1]);
	endproperty
	a_exc_irq: assert property (p_exc_irq) else $error("interrupt pc wrong"); // see RQ8

	property p_soft;
		@(posedge clk_i) disable iff (rst_i)
		soft_irq_o == (soft_int_request_i & ien_q[15:1]);
	endproperty
	a_soft: assert property (p_soft) else $error("soft interrupt gating wrong"); // see RQ18

	property p_inv_space;
		@(posedge clk_i) disable iff (rst_i)
		(inv_wr && !tb_fill_i && tags_q[0].valid && tags_q[0].gran_hint == 2'h0 && tags_q[0].vpn == inv_vpn
			&& tags_q[0].space_id == ctx_space_id_i) |=> !tb_valid_o[0];
	endproperty
	a_inv_space: assert property (p_inv_space) else $error("entry not invalidated"); // see RQ1

	property p_inv_all_space;
		@(posedge clk_i) disable iff (rst_i)
		(inv_wr && !tb_fill_i && tags_q[2].valid && tags_q[2].gran_hint == 2'h0 && tags_q[2].vpn == inv_vpn
			&& tags_q[2].all_space_match_bit) |=> !tb_valid_o[2];
	endproperty
	a_inv_all_space: assert property (p_inv_all_space) else $error("all-space entry kept"); // see RQ2

	property p_inv_keep;
		@(posedge clk_i) disable iff (rst_i)
		(inv_wr && !tb_fill_i && tags_q[1].valid && !tags_q[1].all_space_match_bit
			&& tags_q[1].space_id != ctx_space_id_i) |=> tb_valid_o[1];
	endproperty
	a_inv_keep: assert property (p_inv_keep) else $error("foreign space entry killed"); // see RQ1

	property p_ien_write;
		@(posedge clk_i) disable iff (rst_i)
		(req_i.wr && iem_sel && req_i.idx[1]) |=> ien_q == $past(req_i.wdata[38:13]);
	endproperty
	a_ien_write: assert property (p_ien_write) else $error("enables not written"); // see RQ12

	property p_prof_priv;
		@(posedge clk_i) disable iff (rst_i)
		profile_i |=> prof_pc_q[0] == $past(profile_phys_i);
	endproperty
	a_prof_priv: assert property (p_prof_priv) else $error("profiled pc mode flag wrong"); // see RQ5

	property p_async_gate;
		@(posedge clk_i) disable iff (rst_i)
		(async_trap_o & ~(async_trap_request_i & async_trap_mask_i)) == 4'h0
			&& (ien_q[0] || async_trap_o == 4'h0);
	endproperty
	a_async_gate: assert property (p_async_gate) else $error("async trap gating wrong"); // see RQ16
endmodule

//--- sim/instr_unit_control_regs_test.sv
// Self-checking bench for the instruction-unit privileged register block.
// Assumes the design's own assertions sit in its files; drives every port directly.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
	$display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module instr_unit_control_regs_test;
	logic                                    clk_i;
	logic                                    rst_i;
	instr_unit_pkg::priv_req_t               req_i;
	logic [63:0]                             rdata_o;
	logic                                    tb_fill_i;
	instr_unit_pkg::tb_tag_t                 tb_fill_tag_i;
	logic [3:0]                              tb_fill_slot_i;
	logic [15:0]                             tb_valid_o;
	logic                                    icache_flush_o;
	logic [7:0]                              ctx_space_id_i;
	logic                                    profile_i;
	logic [63:0]                             profile_pc_i;
	logic                                    profile_phys_i;
	instr_unit_pkg::exc_event_t              exc_i;
	logic [33:0]                             page_table_base_i;
	logic                                    wide_va_select_i;
	logic                                    short_pte_format_i;
	logic [14:0]                             soft_int_request_i;
	logic [3:0]                              async_trap_mask_i;
	logic [3:0]                              async_trap_request_i;
	logic [14:0]                             soft_irq_o;
	logic [3:0]                              async_trap_o;
	logic [1:0]                              privilege_level_o;
	int                                      n_mismatch = 0;
	int                                      n_compared = 0;
	logic [63:0]                             q;
	logic [34:0]                             vpn_a = 35'h1_2345_6788;

	instr_unit_control_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
		.tb_fill_i(tb_fill_i), .tb_fill_tag_i(tb_fill_tag_i), .tb_fill_slot_i(tb_fill_slot_i),
		.tb_valid_o(tb_valid_o), .icache_flush_o(icache_flush_o), .ctx_space_id_i(ctx_space_id_i),
		.profile_i(profile_i), .profile_pc_i(profile_pc_i), .profile_phys_i(profile_phys_i), .exc_i(exc_i),
		.page_table_base_i(page_table_base_i), .wide_va_select_i(wide_va_select_i),
		.short_pte_format_i(short_pte_format_i), .soft_int_request_i(soft_int_request_i),
		.async_trap_mask_i(async_trap_mask_i), .async_trap_request_i(async_trap_request_i),
		.soft_irq_o(soft_irq_o), .async_trap_o(async_trap_o), .privilege_level_o(privilege_level_o));

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Each access takes one edge, then one idle edge, so no strobe is set twice in a step
	task automatic reg_wr(input logic [7:0] idx, input logic [63:0] d);
		@(posedge clk_i) req_i <= '{1'b1, 1'b0, idx, d};
		@(posedge clk_i) req_i <= '0;
		#1;
	endtask

	task automatic reg_rd(input logic [7:0] idx, output logic [63:0] r);
		@(posedge clk_i) req_i <= '{1'b0, 1'b1, idx, 64'h0};
		@(posedge clk_i) req_i <= '0;
		#1 r = rdata_o;
	endtask

	task automatic exc_pulse(input logic f, input logic irq, input logic [63:0] fpc, input logic [63:0] npc,
		input logic pm);
		@(posedge clk_i) exc_i <= '{f, irq, fpc, npc, pm};
		@(posedge clk_i) exc_i <= '0;
		#1;
	endtask

	task automatic fill(input logic [3:0] slot, input instr_unit_pkg::tb_tag_t tag);
		@(posedge clk_i) begin
			tb_fill_i <= 1'b1;
			tb_fill_slot_i <= slot;
			tb_fill_tag_i <= tag;
		end
		@(posedge clk_i) tb_fill_i <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset_values();
		reg_rd(8'h08, q);
		`CHK("ien_cm reset", 64'h0, q)
		`CHK("mode reset", 2'h0, privilege_level_o)
		`CHK("tb valid reset", 16'h0, tb_valid_o)
	endtask

	task automatic t_enable_mode();
		reg_wr(8'h0a, 64'hffffffff_ffffffff);
		reg_rd(8'h08, q);
		`CHK("enables only", 64'h0000007f_ffffe000, q)
		`CHK("mode kept", 2'h0, privilege_level_o)
		@(posedge clk_i);
		soft_int_request_i <= 15'h1234;
		async_trap_mask_i <= 4'ha;
		async_trap_request_i <= 4'hc;
		#1;
		`CHK("soft irq", 15'h1234, soft_irq_o)
		`CHK("async trap", 4'h8, async_trap_o)
		for (int m = 0; m < 4; m++) begin
			reg_wr(8'h09, 64'(m) << 3);
			`CHK("mode code", 2'(m), privilege_level_o)
		end
		reg_wr(8'h08, 64'h0);
		reg_rd(8'h0b, q);
		`CHK("no field enable", 64'h0000007f_ffffe018, q)
		// Reserved bits are set in the write to show they do not stick
		reg_wr(8'h0b, 64'hffffffd5_55555ff7);
		reg_rd(8'h09, q);
		`CHK("both fields", 64'h00000055_55554010, q)
		`CHK("mode both", 2'h2, privilege_level_o)
		@(posedge clk_i);
		soft_int_request_i <= 15'h7fff;
		async_trap_mask_i <= 4'hf;
		async_trap_request_i <= 4'hf;
		#1;
		`CHK("soft gated", 15'h5555, soft_irq_o)
		`CHK("async off", 4'h0, async_trap_o)
	endtask

	task automatic t_pcs();
		@(posedge clk_i) begin
			profile_i <= 1'b1;
			profile_pc_i <= 64'h01234567_89abcdef;
			profile_phys_i <= 1'b1;
		end
		@(posedge clk_i) profile_i <= 1'b0;
		reg_wr(8'h04, 64'h0);
		reg_rd(8'h04, q);
		`CHK("profiled pc", 64'h01234567_89abcded, q)
		exc_pulse(1'b1, 1'b1, 64'h00000aaa_bbbbc000, 64'h11110000_22223331, 1'b1);
		reg_rd(8'h06, q);
		`CHK("fault pc", 64'h00000aaa_bbbbc001, q)
		exc_pulse(1'b0, 1'b1, 64'h00000aaa_bbbbc000, 64'h11110000_22223331, 1'b0);
		reg_rd(8'h06, q);
		`CHK("irq next pc", 64'h11110000_22223330, q)
		reg_rd(8'h05, q);
		`CHK("unmapped read", 64'h0, q)
	endtask

	task automatic t_pte_format();
		exc_pulse(1'b1, 1'b0, 64'hffff7654_3210e000, 64'h0, 1'b0);
		@(posedge clk_i);
		page_table_base_i <= 34'h2_0000_0000;
		wide_va_select_i <= 1'b0;
		short_pte_format_i <= 1'b0;
		reg_rd(8'h07, q);
		`CHK("pte 43", 64'h80000001_950c8438, q)
		@(posedge clk_i);
		wide_va_select_i <= 1'b1;
		reg_rd(8'h07, q);
		`CHK("pte 48", 64'h8000001d_950c8438, q)
		@(posedge clk_i);
		wide_va_select_i <= 1'b0;
		short_pte_format_i <= 1'b1;
		reg_rd(8'h07, q);
		`CHK("pte short", 64'h80000000_000c8438, q)
	endtask

	task automatic t_invalidate();
		@(posedge clk_i);
		ctx_space_id_i <= 8'h05;
		fill(4'h0, '{1'b1, vpn_a, 8'h05, 1'b0, 2'h0});
		fill(4'h1, '{1'b1, vpn_a, 8'h06, 1'b0, 2'h0});
		fill(4'h2, '{1'b1, vpn_a, 8'h06, 1'b1, 2'h0});
		fill(4'h3, '{1'b1, vpn_a ^ 35'h100, 8'h05, 1'b0, 2'h0});
		fill(4'h4, '{1'b1, vpn_a | 35'h5, 8'h05, 1'b0, 2'h1});
		fill(4'h5, '{1'b1, vpn_a | 35'h5, 8'h05, 1'b0, 2'h0});
		#1;
		`CHK("filled", 16'h003f, tb_valid_o)
		reg_wr(8'h03, {16'h0, vpn_a, 13'h0});
		`CHK("invalidated", 16'h002a, tb_valid_o)
		`CHK("no cache flush", 1'b0, icache_flush_o)
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_i = 1'b1;
		req_i = '0;
		tb_fill_i = 1'b0;
		tb_fill_tag_i = '0;
		tb_fill_slot_i = 4'h0;
		ctx_space_id_i = 8'h00;
		profile_i = 1'b0;
		profile_pc_i = 64'h0;
		profile_phys_i = 1'b0;
		exc_i = '0;
		page_table_base_i = 34'h0;
		wide_va_select_i = 1'b0;
		short_pte_format_i = 1'b0;
		soft_int_request_i = 15'h0;
		async_trap_mask_i = 4'h0;
		async_trap_request_i = 4'h0;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset_values();
		t_enable_mode();
		t_pcs();
		t_pte_format();
		t_invalidate();
		tally_and_finish();
	end

	// The scenarios need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		n_mismatch++;
		tally_and_finish();
	end
endmodule
